// ==== hdl/cfcc_pkg.sv ====
// Shared constants of the dual-channel clocked FIFO control block.
// Assumes one clock domain; all pins are synchronous to that clock.
package cfcc_pkg;
   // Channel shape
   localparam int CFCC_NCH = 2;
   localparam int CFCC_DATA_W = 9;
   localparam int CFCC_DEPTH = 256;
   // Programmable flag offset loaded at reset
   localparam int CFCC_OFF_DEFAULT = 7;
   // Register bus shape
   localparam int CFCC_ADDR_W = 8;
   localparam int CFCC_BUS_W = 32;
   // Register byte addresses
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_AE_OFF_A = 8'h04;
   localparam logic [7:0] REG_AF_OFF_A = 8'h08;
   localparam logic [7:0] REG_AE_OFF_B = 8'h0C;
   localparam logic [7:0] REG_AF_OFF_B = 8'h10;
   localparam logic [7:0] REG_LEVEL_A = 8'h14;
   localparam logic [7:0] REG_LEVEL_B = 8'h18;
   // Status register layout: mode bits, then four flags per channel
   localparam int ST_MODE_LSB = 0;
   localparam int ST_FLAG_LSB = 4;
   localparam int ST_FLAG_W = 4;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : cfcc_pkg

// ==== hdl/cfcc_mode.sv ====
// Per-channel mode strap and pin-driven offset loader.
// Assumes chan_rst_n and the shared pin are synchronous to aclk.
`timescale 1ns/1ps
module cfcc_mode
   import cfcc_pkg::*;
#(
   parameter int WIDTH = CFCC_DATA_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic chan_rst_n,
   input wire logic sec_in,
   input wire logic wen1_n,
   input wire logic [WIDTH-1:0] din,
   output logic mode_dual,
   output logic ld_ae,
   output logic ld_af,
   output logic [WIDTH-1:0] ld_data
);
   logic sel; // Which offset the next pin load fills
   logic ld_go; // Pin load of one offset word this cycle

   // Loads only happen in flag mode with the load control held low
   assign ld_go = !mode_dual && chan_rst_n && !sec_in && !wen1_n;

   // Strap: the pin level seen during channel reset picks the mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_dual <= 1'b0;
      end else if (!chan_rst_n) begin
         mode_dual <= sec_in;
      end
   end

   // Offset loads alternate almost-empty then almost-full
   always_ff @(posedge aclk) begin
      if (!aresetn || !chan_rst_n) begin
         sel <= 1'b0;
         ld_ae <= 1'b0;
         ld_af <= 1'b0;
         ld_data <= '0;
      end else begin
         ld_ae <= ld_go && !sel;
         ld_af <= ld_go && sel;
         if (ld_go) begin
            ld_data <= din;
            sel <= !sel;
         end else if (sec_in) begin
            // Releasing load restarts the sequence
            sel <= 1'b0;
         end
      end
   end

   strap_dual_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (!chan_rst_n && sec_in) |=> mode_dual ##1 (mode_dual || !chan_rst_n))
      else $error("second write enable mode not taken at reset");
   strap_flag_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (!chan_rst_n && !sec_in) |=> !mode_dual)
      else $error("offset load mode not taken at reset");
endmodule : cfcc_mode

// ==== hdl/cfcc_chan.sv ====
// One FIFO channel: storage, pointers, fill level and four flags.
// Assumes one clock; read and write sides share aclk.
`timescale 1ns/1ps
module cfcc_chan
   import cfcc_pkg::*;
#(
   parameter int DEPTH = CFCC_DEPTH,
   parameter int WIDTH = CFCC_DATA_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic chan_rst_n,
   input wire logic wen1_n,
   input wire logic sec_in,
   input wire logic ren1_n,
   input wire logic ren2_n,
   input wire logic [WIDTH-1:0] din,
   input wire logic [$clog2(DEPTH)-1:0] ae_off,
   input wire logic [$clog2(DEPTH)-1:0] af_off,
   output logic [WIDTH-1:0] q,
   output logic empty_n,
   output logic full_n,
   output logic ae_n,
   output logic af_n,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // Storage array
   logic [AW-1:0] wr_ptr; // Next location written
   logic [AW-1:0] rd_ptr; // Next location read
   logic [AW:0] next_level; // Fill level after this edge
   logic clr; // Device or channel reset
   logic wr_go; // Word accepted this edge
   logic rd_go; // Word taken this edge

   assign clr = !aresetn || !chan_rst_n;
   // Second pin high means enable in dual mode, load released in flag mode
   assign wr_go = !wen1_n && sec_in && full_n;
   assign rd_go = !ren1_n && !ren2_n && empty_n;

   always_comb begin
      next_level = level + {{AW{1'b0}}, wr_go} - {{AW{1'b0}}, rd_go};
   end

   // Storage has no reset, it is only read behind valid pointers
   always_ff @(posedge aclk) begin
      if (wr_go) begin
         mem[wr_ptr] <= din;
      end
   end

   // Pointers return to the first location on reset
   always_ff @(posedge aclk) begin
      if (clr) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (wr_go) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (rd_go) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   // Output register holds while no read is taken
   always_ff @(posedge aclk) begin
      if (clr) begin
         q <= '0;
      end else if (rd_go) begin
         q <= mem[rd_ptr];
      end
   end

   // Flags come from the next level so they track each edge exactly
   always_ff @(posedge aclk) begin
      if (clr) begin
         level <= '0;
         empty_n <= 1'b0;
         ae_n <= 1'b0;
         full_n <= 1'b1;
         af_n <= 1'b1;
      end else begin
         level <= next_level;
         empty_n <= next_level != '0;
         ae_n <= next_level > {1'b0, ae_off};
         full_n <= next_level != (AW+1)'(DEPTH);
         af_n <= next_level < ((AW+1)'(DEPTH) - {1'b0, af_off});
      end
   end

   full_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && !full_n) |=> $stable(wr_ptr))
      else $error("write pointer moved while full");
   empty_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && !empty_n) |=> ($stable(rd_ptr) && $stable(q)))
      else $error("read side moved while empty");
   write_step_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && full_n && !wen1_n && sec_in) |=> wr_ptr == $past(wr_ptr) + 1'b1)
      else $error("qualified write not stored");
   second_low_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && sec_in == 1'b0) |=> $stable(wr_ptr))
      else $error("write taken with second pin low");
   read_step_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && empty_n && !ren1_n && !ren2_n) |=> rd_ptr == $past(rd_ptr) + 1'b1)
      else $error("qualified read not taken");
   empty_flag_a : assert property (@(posedge aclk) disable iff (!aresetn)
      empty_n == (level != '0))
      else $error("empty flag disagrees with level");
   almost_empty_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (chan_rst_n && $stable(ae_off)) |=> (ae_n == (level > {1'b0, $past(ae_off)})))
      else $error("almost-empty flag wrong");
   reset_flags_a : assert property (@(posedge aclk) disable iff (!aresetn)
      !chan_rst_n |=> (!empty_n && !ae_n && full_n && af_n && wr_ptr == '0 && rd_ptr == '0))
      else $error("reset state wrong");
endmodule : cfcc_chan

// ==== hdl/cfcc_top.sv ====
// Dual-channel clocked FIFO control with an AXI4-Lite register slave.
// Assumes every pin is synchronous to aclk; read and write sides share it.
//
// Operation
// - Primary enable low writes word each edge
// - Dual mode: primary low, secondary high writes
// - Full flag low blocks writes, pointer kept
// - Pin high during reset selects dual enable
// - Pin low during reset selects offset loading
// - Both read enables low read next word
// - Empty flag low blocks reads, output kept
// - Output enable low drives, high floats data; here only passed to the oe outputs, data always driven
// - Empty flag low when nothing readable
// - Empty flag updated on read clock
// - Almost-empty low at or below offset
// - Reset loads almost-empty offset seven
// - Almost-empty flag updated on read clock
// - Output data bus is nine bits
// - Reset clears pointers, sets flag levels
// - Full flag low when buffer full
// - Almost-full low near full, default seven
`timescale 1ns/1ps
module cfcc_top
   import cfcc_pkg::*;
#(
   parameter int DEPTH = CFCC_DEPTH,
   parameter int WIDTH = CFCC_DATA_W
) (
   input wire logic aclk,
   input wire logic aresetn,
   // Channel A pins
   input wire logic channel_reset_a_n,
   input wire logic write_enable_primary_a_n,
   input wire logic write_enable_secondary_or_load_a,
   input wire logic read_enable_first_a_n,
   input wire logic read_enable_second_a_n,
   input wire logic output_drive_enable_a_n,
   input wire logic [WIDTH-1:0] input_data_a,
   output logic [WIDTH-1:0] output_data_a,
   output logic output_data_oe_a_n,
   output logic empty_flag_a_n,
   output logic full_flag_a_n,
   output logic almost_empty_flag_a_n,
   output logic almost_full_flag_a_n,
   // Channel B pins
   input wire logic channel_reset_b_n,
   input wire logic write_enable_primary_b_n,
   input wire logic write_enable_secondary_or_load_b,
   input wire logic read_enable_first_b_n,
   input wire logic read_enable_second_b_n,
   input wire logic output_drive_enable_b_n,
   input wire logic [WIDTH-1:0] input_data_b,
   output logic [WIDTH-1:0] output_data_b,
   output logic output_data_oe_b_n,
   output logic empty_flag_b_n,
   output logic full_flag_b_n,
   output logic almost_empty_flag_b_n,
   output logic almost_full_flag_b_n,
   // AXI4-Lite slave
   input wire logic [CFCC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [CFCC_BUS_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CFCC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [CFCC_BUS_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int OW = $clog2(DEPTH); // Offset and pointer width
   localparam int LW = OW + 1; // Fill level width

   // Offsets must fit a 16-bit register field, depth must be a power of two
   if (DEPTH < 16 || DEPTH > 32768 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
   begin : g_bad_param
      $error("cfcc_top: DEPTH must be a power of two in 16..32768");
   end

   typedef enum {CFCC_WR_IDLE, CFCC_WR_RESP} cfcc_wr_e; // Write channel
   typedef enum {CFCC_RD_IDLE, CFCC_RD_DATA} cfcc_rd_e; // Read channel

   // Pins gathered per channel, index 0 is A and 1 is B
   logic [CFCC_NCH-1:0] chan_rst_n;
   logic [CFCC_NCH-1:0] wen1_n;
   logic [CFCC_NCH-1:0] sec_in;
   logic [CFCC_NCH-1:0] ren1_n;
   logic [CFCC_NCH-1:0] ren2_n;
   logic [CFCC_NCH-1:0][WIDTH-1:0] din;
   // Per-channel results
   logic [CFCC_NCH-1:0][WIDTH-1:0] q;
   logic [CFCC_NCH-1:0] empty_n;
   logic [CFCC_NCH-1:0] full_n;
   logic [CFCC_NCH-1:0] ae_n;
   logic [CFCC_NCH-1:0] af_n;
   logic [CFCC_NCH-1:0][LW-1:0] level;
   logic [CFCC_NCH-1:0] mode_dual;
   logic [CFCC_NCH-1:0] ld_ae;
   logic [CFCC_NCH-1:0] ld_af;
   logic [CFCC_NCH-1:0][WIDTH-1:0] ld_data;
   // Offset registers, written by software or by pin loads
   logic [CFCC_NCH-1:0][OW-1:0] ae_off;
   logic [CFCC_NCH-1:0][OW-1:0] af_off;

   // Bus state
   cfcc_wr_e wr_state;
   cfcc_rd_e rd_state;
   logic aw_held; // Write address captured
   logic w_held; // Write data captured
   logic [CFCC_ADDR_W-1:0] waddr; // Captured write address
   logic [CFCC_BUS_W-1:0] wdata; // Captured write data
   logic [3:0] wstrb; // Captured byte strobes
   logic do_wr; // Register write happens this edge
   logic wr_hit; // Captured address is writable
   logic rd_hit; // Read address is mapped
   logic [CFCC_BUS_W-1:0] rd_word; // Read mux result
   logic [CFCC_BUS_W-1:0] status; // Mode and flag snapshot

   assign chan_rst_n = {channel_reset_b_n, channel_reset_a_n};
   assign wen1_n = {write_enable_primary_b_n, write_enable_primary_a_n};
   assign sec_in = {write_enable_secondary_or_load_b, write_enable_secondary_or_load_a};
   assign ren1_n = {read_enable_first_b_n, read_enable_first_a_n};
   assign ren2_n = {read_enable_second_b_n, read_enable_second_a_n};
   assign din = {input_data_b, input_data_a};

   // Flags and data leave straight from the channel flip-flops
   assign output_data_a = q[0];
   assign output_data_b = q[1];
   assign empty_flag_a_n = empty_n[0];
   assign empty_flag_b_n = empty_n[1];
   assign full_flag_a_n = full_n[0];
   assign full_flag_b_n = full_n[1];
   assign almost_empty_flag_a_n = ae_n[0];
   assign almost_empty_flag_b_n = ae_n[1];
   assign almost_full_flag_a_n = af_n[0];
   assign almost_full_flag_b_n = af_n[1];

   // Three-state control passes through without a clock, as the pin must
   assign output_data_oe_a_n = output_drive_enable_a_n;
   assign output_data_oe_b_n = output_drive_enable_b_n;

   // Merge byte strobes into the low half-word of a register
   function automatic logic [15:0] merge_strb(input logic [15:0] old,
                                              input logic [CFCC_BUS_W-1:0] data,
                                              input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction : merge_strb

   // Each channel is a separate instance with its own state
   for (genvar c = 0; c < CFCC_NCH; c++) begin : g_chan
      localparam logic [7:0] AE_ADDR = (c == 0) ? REG_AE_OFF_A : REG_AE_OFF_B;
      localparam logic [7:0] AF_ADDR = (c == 0) ? REG_AF_OFF_A : REG_AF_OFF_B;

      // Strap capture and pin-driven offset loads
      cfcc_mode #(
         .WIDTH(WIDTH)
      ) u_mode (
         .aclk(aclk),
         .aresetn(aresetn),
         .chan_rst_n(chan_rst_n[c]),
         .sec_in(sec_in[c]),
         .wen1_n(wen1_n[c]),
         .din(din[c]),
         .mode_dual(mode_dual[c]),
         .ld_ae(ld_ae[c]),
         .ld_af(ld_af[c]),
         .ld_data(ld_data[c])
      );

      // Storage, pointers and flags
      cfcc_chan #(
         .DEPTH(DEPTH),
         .WIDTH(WIDTH)
      ) u_chan (
         .aclk(aclk),
         .aresetn(aresetn),
         .chan_rst_n(chan_rst_n[c]),
         .wen1_n(wen1_n[c]),
         .sec_in(sec_in[c]),
         .ren1_n(ren1_n[c]),
         .ren2_n(ren2_n[c]),
         .din(din[c]),
         .ae_off(ae_off[c]),
         .af_off(af_off[c]),
         .q(q[c]),
         .empty_n(empty_n[c]),
         .full_n(full_n[c]),
         .ae_n(ae_n[c]),
         .af_n(af_n[c]),
         .level(level[c])
      );

      // Offsets default on any reset; a pin load beats a bus write
      always_ff @(posedge aclk) begin
         if (!aresetn || !chan_rst_n[c]) begin
            ae_off[c] <= OW'(CFCC_OFF_DEFAULT);
            af_off[c] <= OW'(CFCC_OFF_DEFAULT);
         end else begin
            if (ld_ae[c]) begin
               ae_off[c] <= OW'(ld_data[c]);
            end else if (do_wr && waddr == AE_ADDR) begin
               ae_off[c] <= OW'(merge_strb(16'(ae_off[c]), wdata, wstrb));
            end
            if (ld_af[c]) begin
               af_off[c] <= OW'(ld_data[c]);
            end else if (do_wr && waddr == AF_ADDR) begin
               af_off[c] <= OW'(merge_strb(16'(af_off[c]), wdata, wstrb));
            end
         end
      end

      // Status snapshot for software
      assign status[ST_MODE_LSB + c] = mode_dual[c];
      assign status[ST_FLAG_LSB + ST_FLAG_W * c +: ST_FLAG_W] =
         {full_n[c], af_n[c], ae_n[c], empty_n[c]};

      offset_default_a : assert property (@(posedge aclk) disable iff (!aresetn)
         !chan_rst_n[c] |=> (ae_off[c] == OW'(CFCC_OFF_DEFAULT)
                             && af_off[c] == OW'(CFCC_OFF_DEFAULT)))
         else $error("offset default not loaded at reset");
   end : g_chan

   // Unused status bits read as zero
   assign status[ST_FLAG_LSB-1:CFCC_NCH] = '0;
   assign status[CFCC_BUS_W-1:ST_FLAG_LSB + ST_FLAG_W * CFCC_NCH] = '0;

   // Writable addresses: the four offset registers only
   assign wr_hit = (waddr == REG_AE_OFF_A) || (waddr == REG_AF_OFF_A)
                || (waddr == REG_AE_OFF_B) || (waddr == REG_AF_OFF_B);
   // The write lands once both halves are held and no response is pending
   assign do_wr = (wr_state == CFCC_WR_IDLE) && aw_held && w_held && wr_hit;

   // Write channel: address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= CFCC_WR_IDLE;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         waddr <= '0;
         wdata <= '0;
         wstrb <= '0;
      end else begin
         case (wr_state)
            CFCC_WR_IDLE: begin
               if (s_axi_awvalid && s_axi_awready) begin
                  waddr <= s_axi_awaddr;
                  aw_held <= 1'b1;
                  s_axi_awready <= 1'b0;
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  wdata <= s_axi_wdata;
                  wstrb <= s_axi_wstrb;
                  w_held <= 1'b1;
                  s_axi_wready <= 1'b0;
               end
               // Unmapped or read-only targets answer with an error
               if (aw_held && w_held) begin
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                  wr_state <= CFCC_WR_RESP;
               end
            end
            CFCC_WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
                  aw_held <= 1'b0;
                  w_held <= 1'b0;
                  wr_state <= CFCC_WR_IDLE;
               end
            end
            default: begin
               wr_state <= CFCC_WR_IDLE;
            end
         endcase
      end
   end

   // Read address decode
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         REG_STATUS: rd_word = status;
         REG_AE_OFF_A: rd_word = CFCC_BUS_W'(ae_off[0]);
         REG_AF_OFF_A: rd_word = CFCC_BUS_W'(af_off[0]);
         REG_AE_OFF_B: rd_word = CFCC_BUS_W'(ae_off[1]);
         REG_AF_OFF_B: rd_word = CFCC_BUS_W'(af_off[1]);
         REG_LEVEL_A: rd_word = CFCC_BUS_W'(level[0]);
         REG_LEVEL_B: rd_word = CFCC_BUS_W'(level[1]);
         default: rd_hit = 1'b0;
      endcase
   end

   // Read channel: one read at a time, data one edge after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= CFCC_RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         case (rd_state)
            CFCC_RD_IDLE: begin
               if (s_axi_arvalid) begin
                  s_axi_rdata <= rd_word;
                  s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                  s_axi_rvalid <= 1'b1;
                  s_axi_arready <= 1'b0;
                  rd_state <= CFCC_RD_DATA;
               end
            end
            CFCC_RD_DATA: begin
               if (s_axi_rready) begin
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
                  rd_state <= CFCC_RD_IDLE;
               end
            end
            default: begin
               rd_state <= CFCC_RD_IDLE;
            end
         endcase
      end
   end

   bresp_hold_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
      else $error("write response dropped before taken");
   rdata_next_a : assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready) |=> (s_axi_rvalid && !s_axi_arready))
      else $error("read data not presented one edge after address");
endmodule : cfcc_top

// ==== tb/cfcc_agent.sv ====
// Partner: the writing agent of channel A, pushing a counted burst.
// Assumes the bench owns the secondary pin and every reset.
`timescale 1ns/1ps
module cfcc_agent (
   input wire logic aclk,
   input wire logic go,
   input wire logic [4:0] cnt,
   output logic write_enable_primary_a_n,
   output logic [8:0] input_data_a
);
   logic [4:0] left; // Words still to push
   initial begin
      left = 5'h00;
      write_enable_primary_a_n = 1'b1;
      input_data_a = 9'h000;
   end
   // Word carries its own countdown, so order and loss are visible
   always @(posedge aclk) begin
      if (go) begin
         left <= cnt;
      end else if (left != 5'h00) begin
         write_enable_primary_a_n <= 1'b0;
         input_data_a <= {4'hA, left};
         left <= left - 5'h01;
      end else begin
         write_enable_primary_a_n <= 1'b1;
         input_data_a <= ~input_data_a; // Released bus must not hold
      end
   end
endmodule : cfcc_agent

// ==== tb/tb_cfcc_top.sv ====
// Bench of the dual FIFO channel control: pins, flags, register bus.
// Assumes the agent model drives the channel A write side.
`timescale 1ns/1ps
module tb_cfcc_top;
   import cfcc_pkg::*;
   localparam int DEPTH = 16; // Short buffer keeps fills brief
   logic aclk, aresetn, channel_reset_a_n, channel_reset_b_n, go;
   logic write_enable_primary_a_n, write_enable_secondary_or_load_a;
   logic write_enable_primary_b_n, write_enable_secondary_or_load_b;
   logic read_enable_first_a_n, read_enable_second_a_n, output_drive_enable_a_n;
   logic read_enable_first_b_n, read_enable_second_b_n, output_drive_enable_b_n;
   logic [8:0] input_data_a, input_data_b, output_data_a, output_data_b;
   logic output_data_oe_a_n, empty_flag_a_n, full_flag_a_n, output_data_oe_b_n;
   logic almost_empty_flag_a_n, almost_full_flag_a_n, empty_flag_b_n, full_flag_b_n;
   logic almost_empty_flag_b_n, almost_full_flag_b_n, s_axi_awvalid, s_axi_awready;
   logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [4:0] cnt;
   int err_total = 0, cmp_count = 0, cyc = 0;
   wire [3:0] flg_a = {full_flag_a_n, almost_full_flag_a_n, almost_empty_flag_a_n,
      empty_flag_a_n};
   wire [3:0] flg_b = {full_flag_b_n, almost_full_flag_b_n, almost_empty_flag_b_n,
      empty_flag_b_n};
   cfcc_top #(.DEPTH(DEPTH)) DUT (.*);
   cfcc_agent agent (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // Hang guard: the whole run needs under a hundred cycles
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         err_total++;
         conclude();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   // Bus write: both beats offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'b11;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
   endtask : axr
   initial begin
      {aresetn, channel_reset_a_n, channel_reset_b_n, go, cnt} = '0;
      {write_enable_secondary_or_load_a, write_enable_primary_b_n} = 2'b01;
      write_enable_secondary_or_load_b = 1'b1; // Straps B to dual enable
      {read_enable_first_a_n, read_enable_second_a_n, read_enable_first_b_n} = 3'b111;
      {read_enable_second_b_n, output_drive_enable_a_n, output_drive_enable_b_n} = 3'b100;
      {input_data_b, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      // Channel resets outlast the device reset so the mode strap is taken
      @(posedge aclk);
      {channel_reset_a_n, channel_reset_b_n} <= 2'b11;
      @(posedge aclk);
      #1 chk("flags_a", 32'hC, flg_a);
      chk("flags_b", 32'hC, flg_b);
      axr(REG_AE_OFF_A);
      chk("ae_off_a", 32'h7, rd);
      axr(REG_STATUS);
      chk("status", 32'hCC2, rd);
      axr(8'h40);
      chk("rd_resp", RESP_SLVERR, rs);
      $display("reset test done");
      // Seventeen pushes into sixteen places: the last one must bounce
      write_enable_secondary_or_load_a <= 1'b1;
      {go, cnt} <= 6'h31;
      @(posedge aclk);
      go <= 1'b0;
      repeat (20) @(posedge aclk);
      #1 chk("flags_full", 32'h3, flg_a);
      axr(REG_LEVEL_A);
      chk("level_a", 32'h10, rd);
      {read_enable_first_a_n, read_enable_second_a_n} <= 2'b00;
      for (int k = 0; k < 17; k++) begin
         @(posedge aclk);
         #1 chk("word_a", 32'h151 - (k < 16 ? k : 15), output_data_a);
         chk("ae_a", k < 8, almost_empty_flag_a_n);
      end
      @(posedge aclk);
      {read_enable_first_a_n, read_enable_second_a_n} <= 2'b11;
      #1 chk("flags_empty", 32'hC, flg_a);
      for (int v = 0; v < 2; v++) begin
         @(posedge aclk);
         output_drive_enable_a_n <= v[0];
         #1 chk("oe_a", v[0], output_data_oe_a_n);
      end
      $display("fifo test done");
      // Pin load in flag mode: almost-empty then almost-full, no stored word
      @(posedge aclk);
      write_enable_secondary_or_load_a <= 1'b0;
      {go, cnt} <= 6'h22;
      @(posedge aclk);
      go <= 1'b0;
      repeat (4) @(posedge aclk);
      write_enable_secondary_or_load_a <= 1'b1;
      axr(REG_AE_OFF_A);
      chk("pin_ae_off", 32'h2, rd);
      chk("no_write", 1'b0, empty_flag_a_n);
      axr(REG_AF_OFF_A);
      chk("pin_af_off", 32'h1, rd);
      axw(REG_AF_OFF_A, 32'h3);
      chk("wr_resp", RESP_OKAY, rs);
      axr(REG_AF_OFF_A);
      chk("af_off_a", 32'h3, rd);
      axw(8'h44, 32'h5);
      chk("bad_wr", RESP_SLVERR, rs);
      $display("offset test done");
      // Channel B in dual mode: secondary low must block the write
      input_data_b <= 9'h1A5;
      write_enable_primary_b_n <= 1'b0;
      write_enable_secondary_or_load_b <= 1'b0;
      repeat (2) @(posedge aclk);
      #1 chk("dual_block", 1'b0, empty_flag_b_n);
      @(posedge aclk);
      write_enable_secondary_or_load_b <= 1'b1;
      @(posedge aclk);
      write_enable_primary_b_n <= 1'b1;
      {read_enable_first_b_n, read_enable_second_b_n} <= 2'b00;
      @(posedge aclk);
      #1 chk("word_b", 32'h1A5, output_data_b);
      chk("flags_b_end", 32'hC, flg_b);
      chk("oe_b", 1'b0, output_data_oe_b_n);
      $display("dual test done");
      conclude();
   end
endmodule : tb_cfcc_top
